// ---- hdl/pdc_consts.svh ----
/*
  Constants of the packed decimal codec: field positions, format figures and step counts.
  Assumes inclusion by the codec module only; holds definitions only.
*/
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

`define PDC_SIGN_BIT   79
`define PDC_EXP_HI     78
`define PDC_EXP_LO     64
`define PDC_SIG_HI     63
`define PDC_DIG_HI     71
`define PDC_PAD_HI     78
`define PDC_PAD_LO     72
`define PDC_BIAS       15'd16383
`define PDC_SIG_TOP    15'd63
`define PDC_EXP_ONES   15'h7FFF
`define PDC_MAX_MAG    60'd999999999999999999
`define PDC_INDEF      80'hFFFF_C000_0000_0000_0000
`define PDC_DIG_STEPS  6'd17
`define PDC_BIN_STEPS  6'd59
`define PDC_DIG_MAX    4'h9
`define PDC_RC_NEAR    2'h0
`define PDC_RC_DOWN    2'h1
`define PDC_RC_UP      2'h2

`endif

// ---- hdl/pdc_pkg.sv ----
/*
  Types of the packed decimal codec: operations, states, request and answer carriers.
  Assumes nothing of its surroundings.
*/
package pdc_pkg;

  typedef enum logic [1:0] {
    OP_LOAD     = 2'h0,
    OP_STORE    = 2'h1,
    OP_UNPACKED = 2'h2,
    OP_PACKED   = 2'h3
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACC  = 4'b0010,
    ST_NORM = 4'b0100,
    ST_DAB  = 4'b1000
  } state_t;

  typedef struct packed {
    op_t         op;
    logic [79:0] data;
    logic [1:0]  rc;
    logic        inv_mask;
  } req_t;

  typedef struct packed {
    logic [79:0] data;
    logic        invalid;
    logic        digit_err;
    logic        write;
  } rsp_t;

endpackage : pdc_pkg

// ---- hdl/packed_decimal_codec.sv ----
/*
  Packed decimal codec: decimal bytes to binary, 80-bit decimal integer to and from
  double extended floating point.
  Assumes a requester on the same clock that holds its request while ready is low.
*/
`timescale 1ns/10ps
`include "pdc_consts.svh"

// Contract
// - Every decimal digit is a 4-bit value whose legal range is zero to nine.
// - An unpacked decimal byte takes its value from bits 0 to 3 only.
// - A packed byte holds two digits, the upper nibble being the more significant.
// - The decimal format holds eighteen digits in its first nine bytes, two per byte.
// - The lowest nibble of byte 0 holds the least significant digit, rising upward.
// - Bit 79 is the sign, 0 positive and 1 negative, and bits 72 to 78 are ignored on input.
// - Negative values are sign plus magnitude with no two's complement.
// - The magnitude reaches ten to the eighteenth minus one with either sign, both zeros valid.
// - A decimal load converts to double extended floating point exactly.
// - A masked invalid store writes the decimal indefinite pattern.
// - Loading the indefinite pattern gives an undefined result.
// - The integer significand bit sits at bit 63 with the fraction below it.
// - The exponent carries a bias of 16383.
module packed_decimal_codec
  import pdc_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic req_valid_i,
  output logic      req_ready_o,
  input  wire req_t req_i,
  output logic      rsp_valid_o,
  output rsp_t      rsp_o
);

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------
  state_t        state_r, state_nxt;
  logic [5:0]    cnt_r, cnt_nxt;
  logic [59:0]   acc_r, acc_nxt;
  logic [71:0]   bcd_r, bcd_nxt;
  logic          sign_r, sign_nxt;
  logic          bad_r, bad_nxt;
  logic          mask_r, mask_nxt;
  rsp_t          rsp_r, rsp_nxt;
  logic          rsp_valid_r, rsp_valid_nxt;

  logic          fire;
  logic [14:0]   fp_exp;
  logic [63:0]   fp_sig;
  logic signed [17:0] e_s;
  logic signed [17:0] sh_s;
  logic          huge;
  logic          tiny;
  logic [127:0]  wide;
  logic [63:0]   int_p;
  logic          half;
  logic          stk;
  logic          inc;
  logic [64:0]   rnd;
  logic          inval;
  logic [71:0]   dab_adj;
  logic [3:0]    dig;
  logic [3:0]    hi_n;
  logic [3:0]    lo_n;
  logic [6:0]    lz;

  assign fire        = req_valid_i && req_ready_o;
  assign req_ready_o = (state_r == ST_IDLE);
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_o       = rsp_r;

  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    logic [6:0] n;
    n = 7'd64;
    for (int i = 0; i < 64; i++) begin
      if (v[i]) begin
        n = 7'(63 - i);
      end
    end
    return n;
  endfunction : lead_zeros

  //--------------------------------------------------------------
  // Digit adjust for binary to decimal shifting
  //--------------------------------------------------------------
  for (genvar g = 0; g < 18; g++) begin : g_dab
    assign dab_adj[g*4 +: 4] = (bcd_r[g*4 +: 4] > 4'h4) ? bcd_r[g*4 +: 4] + 4'h3
                                                        : bcd_r[g*4 +: 4];
  end

  //--------------------------------------------------------------
  // Store rounding
  //--------------------------------------------------------------
  always_comb begin
    fp_exp = req_i.data[`PDC_EXP_HI:`PDC_EXP_LO];
    fp_sig = req_i.data[`PDC_SIG_HI:0];
    e_s    = $signed({3'b000, fp_exp}) - $signed({3'b000, `PDC_BIAS});
    // integer bit at 63 sets the shift
    sh_s   = 18'sd63 - e_s;
    huge   = e_s > 18'sd63;
    tiny   = sh_s > 18'sd127;
    wide   = {fp_sig, 64'h0} >> sh_s[6:0];
    int_p  = (huge || tiny) ? 64'h0 : wide[127:64];
    half   = !huge && !tiny && wide[63];
    stk    = tiny ? |fp_sig : (!huge && |wide[62:0]);
    case (req_i.rc)
      `PDC_RC_NEAR: inc = half && (stk || int_p[0]);
      `PDC_RC_DOWN: inc = req_i.data[`PDC_SIGN_BIT] && (half || stk);
      `PDC_RC_UP:   inc = !req_i.data[`PDC_SIGN_BIT] && (half || stk);
      default:      inc = 1'b0;
    endcase
    rnd    = {1'b0, int_p} + {64'h0, inc};
    // symmetric range limit; specials and overflow flag
    inval  = (fp_exp == `PDC_EXP_ONES) || huge || (rnd > {5'h0, `PDC_MAX_MAG});
  end

  //--------------------------------------------------------------
  // Sequencer next state
  //--------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    acc_nxt       = acc_r;
    bcd_nxt       = bcd_r;
    sign_nxt      = sign_r;
    bad_nxt       = bad_r;
    mask_nxt      = mask_r;
    rsp_nxt       = rsp_r;
    rsp_valid_nxt = 1'b0;
    dig           = bcd_r[`PDC_DIG_HI -: 4];
    // unpacked value is the low nibble only
    lo_n          = req_i.data[3:0];
    hi_n          = req_i.data[7:4];
    lz            = lead_zeros({4'h0, acc_r});
    case (state_r)
      ST_IDLE: begin
        if (fire) begin
          // sign taken from bit 79, pad bits unused
          sign_nxt = req_i.data[`PDC_SIGN_BIT];
          mask_nxt = req_i.inv_mask;
          case (req_i.op)
            OP_LOAD: begin
              // eighteen digits from the low nine bytes
              bcd_nxt   = req_i.data[`PDC_DIG_HI:0];
              acc_nxt   = 60'h0;
              bad_nxt   = 1'b0;
              cnt_nxt   = `PDC_DIG_STEPS;
              state_nxt = ST_ACC;
            end
            OP_STORE: begin
              acc_nxt   = rnd[59:0];
              bcd_nxt   = 72'h0;
              bad_nxt   = inval;
              cnt_nxt   = `PDC_BIN_STEPS;
              state_nxt = ST_DAB;
            end
            OP_UNPACKED: begin
              // upper nibble ignored here, so the requester may leave it set, as the bench does with random and 4'hA nibbles
              rsp_nxt       = '{data: {76'h0, lo_n}, invalid: 1'b0,
                                digit_err: lo_n > `PDC_DIG_MAX, write: 1'b1};
              rsp_valid_nxt = 1'b1;
            end
            default: begin
              rsp_nxt       = '{data: {72'h0, {1'b0, hi_n, 3'b000} + {3'b000, hi_n, 1'b0}
                                       + {4'h0, lo_n}},
                                invalid: 1'b0,
                                digit_err: (hi_n > `PDC_DIG_MAX) || (lo_n > `PDC_DIG_MAX),
                                write: 1'b1};
              rsp_valid_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_ACC: begin
        acc_nxt = {acc_r[56:0], 3'b000} + {acc_r[58:0], 1'b0} + {56'h0, dig};
        bcd_nxt = {bcd_r[67:0], 4'h0};
        // non-decimal nibbles give an undefined value, only flagged
        bad_nxt = bad_r || (dig > `PDC_DIG_MAX);
        cnt_nxt = cnt_r - 6'd1;
        if (cnt_r == 6'd0) begin
          state_nxt = ST_NORM;
        end
      end
      ST_NORM: begin
        rsp_nxt.invalid   = 1'b0;
        rsp_nxt.digit_err = bad_r;
        rsp_nxt.write     = 1'b1;
        if (acc_r == 60'h0) begin
          rsp_nxt.data = {sign_r, 79'h0};
        end else begin
          // normalise integer bit to 63; biased exponent
          rsp_nxt.data = {sign_r, `PDC_BIAS + `PDC_SIG_TOP - {8'h0, lz},
                          {4'h0, acc_r} << lz};
        end
        rsp_valid_nxt = 1'b1;
        state_nxt     = ST_IDLE;
      end
      ST_DAB: begin
        bcd_nxt = {dab_adj[70:0], acc_r[59]};
        acc_nxt = {acc_r[58:0], 1'b0};
        cnt_nxt = cnt_r - 6'd1;
        if (cnt_r == 6'd0) begin
          // masked invalid writes indefinite; sign plus magnitude
          rsp_nxt.data      = bad_r ? (mask_r ? `PDC_INDEF : 80'h0)
                                    : {sign_r, 7'h00, dab_adj[70:0], acc_r[59]};
          // invalid reported, unmasked leaves memory alone
          rsp_nxt.invalid   = bad_r;
          rsp_nxt.digit_err = 1'b0;
          rsp_nxt.write     = !bad_r || mask_r;
          rsp_valid_nxt     = 1'b1;
          state_nxt         = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 6'h0;
      acc_r       <= 60'h0;
      bcd_r       <= 72'h0;
      sign_r      <= 1'b0;
      bad_r       <= 1'b0;
      mask_r      <= 1'b0;
      rsp_r       <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      acc_r       <= acc_nxt;
      bcd_r       <= bcd_nxt;
      sign_r      <= sign_nxt;
      bad_r       <= bad_nxt;
      mask_r      <= mask_nxt;
      rsp_r       <= rsp_nxt;
      rsp_valid_r <= rsp_valid_nxt;
    end
  end

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  a_unpacked_digit: assert property (
    fire && req_i.op == OP_UNPACKED |=> rsp_valid_o && rsp_o.data == {76'h0, $past(lo_n)}
      && rsp_o.digit_err == ($past(lo_n) > 4'h9))
    else $error("unpacked byte value or digit flag wrong");

  a_unpacked_high: assert property (
    fire && req_i.op == OP_UNPACKED && req_i.data[3:0] == 4'h5 |=> rsp_o.data[7:0] == 8'h05)
    else $error("unpacked byte used its upper nibble");

  a_packed_weight: assert property (
    fire && req_i.op == OP_PACKED && req_i.data[7:0] == 8'h47 |=> rsp_o.data[7:0] == 8'h2F)
    else $error("packed byte digit weighting wrong");

  a_store_order: assert property (
    fire && req_i.op == OP_STORE && req_i.data == 80'h4002_A000_0000_0000_0000
      |-> ##61 rsp_valid_o && rsp_o.data == 80'h10)
    else $error("store of ten misplaced its digits");

  a_answer_idle: assert property (
    rsp_valid_o |-> req_ready_o)
    else $error("answer raised while the sequencer was busy");

  a_store_neg: assert property (
    fire && req_i.op == OP_STORE && req_i.data == 80'hBFFF_8000_0000_0000_0000
      |-> ##61 rsp_valid_o && rsp_o.data == {1'b1, 79'h1} && rsp_o.write)
    else $error("store of minus one not sign magnitude");

  a_store_sign: assert property (
    fire && req_i.op == OP_STORE |-> ##61 rsp_valid_o && (rsp_o.invalid
      || (rsp_o.data[79] == $past(req_i.data[79], 61) && rsp_o.data[78:72] == 7'h00)))
    else $error("store sign or pad bits wrong");

  a_range_limit: assert property (
    fire && req_i.op == OP_STORE && req_i.data[78:64] == 15'd16443
      && req_i.data[78:64] != 15'h7FFF |-> ##61 rsp_valid_o && rsp_o.invalid)
    else $error("value above range not flagged");

  a_load_exact: assert property (
    fire && req_i.op == OP_LOAD && req_i.data[71:0] == {18{4'h9}}
      |-> ##20 rsp_valid_o && rsp_o.data[78:0] == {15'd16442, 60'd999999999999999999, 4'h0})
    else $error("load of largest value not exact");

  a_masked_indef: assert property (
    fire && req_i.op == OP_STORE && req_i.inv_mask && req_i.data[78:64] == 15'h7FFF
      |-> ##61 rsp_valid_o && rsp_o.data == 80'hFFFF_C000_0000_0000_0000 && rsp_o.write)
    else $error("masked invalid store did not write indefinite");

  a_integer_bit: assert property (
    fire && req_i.op == OP_LOAD && |req_i.data[71:0] && req_i.data[71:0] == {18{4'h0}} + 72'h1
      |-> ##20 rsp_o.data[63] && rsp_o.data[62:0] == 63'h0)
    else $error("integer bit not at 63");

  a_exp_bias: assert property (
    fire && req_i.op == OP_LOAD && req_i.data[71:0] == 72'h1
      |-> ##20 rsp_valid_o && rsp_o.data[78:64] == 15'd16383)
    else $error("exponent bias wrong");

  a_round_up: assert property (
    fire && req_i.op == OP_STORE && req_i.rc == 2'h2 && req_i.data == 80'h3FFE_8000_0000_0000_0000
      |-> ##61 rsp_o.data == 80'h1 && !rsp_o.invalid)
    else $error("round toward plus infinity wrong");

  c_load: cover property (fire && req_i.op == OP_LOAD ##20 rsp_valid_o);
  c_store: cover property (fire && req_i.op == OP_STORE ##61 rsp_valid_o && !rsp_o.invalid);
  c_indef: cover property (rsp_valid_o && rsp_o.invalid && rsp_o.write);
  c_bytes: cover property (fire && req_i.op == OP_PACKED ##1 fire && req_i.op == OP_UNPACKED);

endmodule : packed_decimal_codec

// ---- tb/fp_datapath_model.sv ----
/*
  Requester model of the floating-point datapath that faces the packed decimal codec.
  Assumes the codec clock and a bench that calls issue one request at a time.
*/
`timescale 1ns/10ps

module fp_datapath_model
  import pdc_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic req_ready_i,
  input  wire logic rsp_valid_i,
  input  wire rsp_t rsp_i,
  output logic      req_valid_o,
  output req_t      req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o       = '0;
  end

  // ---------------------------------------------------------------
  // Request and answer
  // ---------------------------------------------------------------
  task automatic issue(input req_t r, output rsp_t q, output int lat);
    logic ok;
    int   n;
    @(posedge clk_sys_i);
    #1;
    req_valid_o = 1'b1;
    req_o       = r;
    n           = 0;
    do begin
      ok = req_ready_i;
      @(posedge clk_sys_i);
      n++;
    end while (!ok && n < 200);
    #1;
    // Released lines show the inverse so stale data never looks valid
    req_valid_o = 1'b0;
    req_o       = ~r;
    // Latency counts from the taking edge; a byte answer already stands here
    lat         = 1;
    while (!rsp_valid_i && lat < 100) begin
      @(posedge clk_sys_i);
      #1;
      lat++;
    end
    q = rsp_i;
  endtask : issue
endmodule : fp_datapath_model

// ---- tb/testbench.sv ----
/*
  Self-checking bench of the packed decimal codec with an integer reference model.
  Assumes the design package and the requester model compiled before it.
*/
`timescale 1ns/10ps

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module testbench;
  import pdc_pkg::*;

  logic clk_sys_i;
  logic arst_n_i;
  logic req_valid;
  logic req_ready;
  logic rsp_valid;
  req_t req;
  rsp_t rsp;
  rsp_t q;
  int   lat;
  int   fail_count  = 0;
  int   check_count = 0;
  int   seed        = 32'h04e9;
  localparam longint unsigned MAX_MAG = 64'd999999999999999999;

  packed_decimal_codec i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_i(req),
    .rsp_valid_o(rsp_valid), .rsp_o(rsp));

  fp_datapath_model i_fp (.clk_sys_i(clk_sys_i), .req_ready_i(req_ready),
    .rsp_valid_i(rsp_valid), .rsp_i(rsp), .req_valid_o(req_valid), .req_o(req));

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  function automatic logic [71:0] bcd(longint unsigned m);
    logic [71:0] r;
    for (int i = 0; i < 18; i++) begin
      r[4*i+:4] = 4'(m % 10);
      m         = m / 10;
    end
    return r;
  endfunction : bcd

  function automatic logic [79:0] fpx(bit s, longint unsigned m);
    int p;
    p = 0;
    if (m == 0) return {s, 79'h0};
    for (int i = 0; i < 64; i++) if (m[i]) p = i;
    return {s, 15'(16383 + p), 64'(m << (63 - p))};
  endfunction : fpx

  function automatic longint unsigned half(longint unsigned m, bit s, logic [1:0] rc);
    longint unsigned h;
    longint unsigned r;
    h = m >> 1;
    r = m & 1;
    case (rc)
      2'h0: return h + (r & h[0]);
      2'h1: return s ? h + r : h;
      2'h2: return s ? h : h + r;
      default: return h;
    endcase
  endfunction : half

  // ---------------------------------------------------------------
  // Bench tasks
  // ---------------------------------------------------------------
  task automatic run(op_t op, logic [79:0] d, logic [1:0] rc, logic m);
    req_t r;
    r = '{op: op, data: d, rc: rc, inv_mask: m};
    i_fp.issue(r, q, lat);
  endtask : run

  task automatic st(logic [79:0] f, logic [1:0] rc, logic m, logic [79:0] e, logic inv);
    run(OP_STORE, f, rc, m);
    `CHK("store data", e, q.data)
    `CHK("store invalid", inv, q.invalid)
    `CHK("store write", !inv || m, q.write)
    `CHK("store latency", 61, lat)
  endtask : st

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // Clock, reset, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #(25 * 20000);
    fail_count++;
    $display("[ERR] watchdog exp done got hang");
    results();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    longint unsigned mags[$];
    logic [3:0]      h;
    logic [3:0]      l;
    bit              s;
    logic [79:0]     f;
    arst_n_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      h = 4'($unsigned($random(seed)) % 10);
      l = 4'($unsigned($random(seed)) % 10);
      run(OP_UNPACKED, {72'h0, 4'($random(seed)), l}, 2'h0, 1'b0);
      `CHK("unpacked data", {76'h0, l}, q.data)
      `CHK("byte latency", 1, lat)
      run(OP_PACKED, {72'h0, h, l}, 2'h0, 1'b0);
      `CHK("packed data", 80'(10 * h + l), q.data)
      `CHK("packed digit_err", 1'b0, q.digit_err)
    end
    run(OP_UNPACKED, 80'h5B, 2'h0, 1'b0);
    `CHK("unpacked bad digit", 1'b1, q.digit_err)
    run(OP_PACKED, 80'hA3, 2'h0, 1'b0);
    `CHK("packed bad high", 1'b1, q.digit_err)
    run(OP_PACKED, 80'h3F, 2'h0, 1'b0);
    `CHK("packed bad low", 1'b1, q.digit_err)
    run(OP_UNPACKED, 80'hA5, 2'h0, 1'b0);
    `CHK("unpacked high nibble", 80'h5, q.data)
    run(OP_PACKED, 80'h47, 2'h0, 1'b0);
    `CHK("packed fixed", 80'h2F, q.data)
    mags = '{64'd0, 64'd1, 64'd10, MAX_MAG};
    for (int i = 0; i < 8; i++) begin
      mags.push_back({$random(seed), $random(seed)} % (MAX_MAG + 1));
    end
    foreach (mags[i]) begin
      for (int k = 0; k < 2; k++) begin
        s = k[0];
        run(OP_LOAD, {s, 7'($random(seed)), bcd(mags[i])}, 2'h0, 1'b0);
        `CHK("load data", fpx(s, mags[i]), q.data)
        `CHK("load digit_err", 1'b0, q.digit_err)
        `CHK("load latency", 20, lat)
        st(fpx(s, mags[i]), 2'($random(seed)), 1'b0, {s, 7'h0, bcd(mags[i])}, 1'b0);
      end
    end
    run(OP_LOAD, {8'h00, 72'h1C}, 2'h0, 1'b0);
    `CHK("load bad digit", 1'b1, q.digit_err)
    run(OP_LOAD, 80'hFFFF_C000_0000_0000_0000, 2'h0, 1'b0);
    `CHK("indefinite load latency", 20, lat)
    for (longint unsigned m = 1; m < 8; m++) begin
      for (int k = 0; k < 8; k++) begin
        s          = k[2];
        f          = fpx(s, m);
        f[78:64]   = f[78:64] - 15'h1;
        st(f, 2'(k), 1'b0, {s, 7'h0, bcd(half(m, s, 2'(k)))}, 1'b0);
      end
    end
    for (int k = 0; k < 2; k++) begin
      st({1'b0, 15'h7FFF, 64'h8000_0000_0000_0000}, 2'h0, k[0],
         k[0] ? 80'hFFFF_C000_0000_0000_0000 : 80'h0, 1'b1);
      st({1'b1, 15'h7FFF, 64'hC000_0000_0000_0000}, 2'h3, k[0],
         k[0] ? 80'hFFFF_C000_0000_0000_0000 : 80'h0, 1'b1);
      st({k[0], 15'd16443, 64'h8000_0000_0000_0000}, 2'h0, k[0],
         k[0] ? 80'hFFFF_C000_0000_0000_0000 : 80'h0, 1'b1);
      st(fpx(k[0], MAX_MAG + 1), 2'h3, k[0],
         k[0] ? 80'hFFFF_C000_0000_0000_0000 : 80'h0, 1'b1);
    end
    results();
  end
endmodule : testbench
